/* axi_host.sv */
/*
 * AXI4-Lite host model with blocking write and read tasks.
 * Assumes a slave on the same aclk; the bench watchdog ends any hang.
 */
`timescale 1ns/100ps
`default_nettype none
module axi_host (
	input  wire logic        aclk,
	output logic [7:0]  s_axi_awaddr,
	output logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0]  s_axi_wstrb,
	output logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic        s_axi_bready,
	output logic [7:0]  s_axi_araddr,
	output logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic        s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
	end
	// ready sampled before the edge lands, so each channel drops when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* irq_pin_drive.v */
/*
 * Interrupt pin driver: three-state open output in 16 mode (active high),
 * driven active-low output in 68 mode. Assumes a pin pad outside resolves
 * the enable.
 */
`timescale 1ns/100ps
`default_nettype none

module irq_pin_drive (
	input  wire aclk,
	input  wire aresetn,
	input  wire bus68_mode,
	input  wire irq_active,
	output reg  irq_pin_o,
	output reg  irq_pin_oe
);
	// float in 16 mode, high in 68 mode
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_pin_o  <= bus68_mode;
			irq_pin_oe <= bus68_mode;
		end else if (bus68_mode) begin
			irq_pin_o  <= ~irq_active;
			irq_pin_oe <= 1'b1;
		end else begin
			irq_pin_o  <= irq_active;
			irq_pin_oe <= irq_active;
		end
	end
endmodule
`default_nettype wire

/* modem_state_track.v */
/*
 * Modem status register: live inverted input levels in the upper nibble,
 * sticky change bits in the lower nibble, cleared on reset and on read.
 * Assumes modem inputs are asynchronous pins, active low.
 */
`timescale 1ns/100ps
`default_nettype none
`include "reset_state_defs.vh"

module modem_state_track (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire [3:0] modem_in_n,
	input  wire       read_strobe,
	output reg  [7:0] modem_state,
	output wire       change_event
);
	reg  [3:0] sync1_q;
	reg  [3:0] sync2_q;
	reg  [3:0] level_q;
	reg  [3:0] delta_q;
	wire [3:0] delta_set;

	assign delta_set    = sync2_q ^ level_q;
	assign change_event = |delta_set;

	always @(posedge aclk) begin
		sync1_q <= modem_in_n;
		sync2_q <= sync1_q;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			// track the pins in reset so no false change follows release
			level_q <= sync2_q;
			delta_q <= 4'h0;
		end else begin
			level_q <= sync2_q;
			// a change in the read cycle survives the clear
			delta_q <= (read_strobe ? 4'h0 : delta_q) | delta_set;
		end
	end

	always @* begin
		modem_state = {~sync2_q, delta_q};
	end
endmodule
`default_nettype wire

/* reset_state_defs.vh */
/*
 * Register offsets, reset values and field positions for the reset-state
 * block of the UART register file. Included by the register file, the modem tracker and the bench.
 */
`ifndef RESET_STATE_DEFS_VH
`define RESET_STATE_DEFS_VH

// register byte offsets on the AXI4-Lite slave
`define OFF_EVENT_ENABLE    8'h00
`define OFF_FIFO_CTRL       8'h04
`define OFF_PENDING_SOURCE  8'h08
`define OFF_LINE_FORMAT     8'h0C
`define OFF_MODEM_CTRL      8'h10
`define OFF_LINE_STATE      8'h14
`define OFF_MODEM_STATE     8'h18
`define OFF_SCRATCH         8'h1C
`define OFF_ENH_MODE_SEL    8'h20
`define OFF_FILL_LEVEL      8'h24
`define OFF_THRESHOLD       8'h28
`define OFF_FIFO_COUNT      8'h2C
`define OFF_FEATURE_CTRL    8'h30
`define OFF_ENH_FEATURE     8'h34
`define OFF_RESUME_1        8'h38
`define OFF_RESUME_2        8'h3C
`define OFF_PAUSE_1         8'h40
`define OFF_PAUSE_2         8'h44
`define OFF_DIVISOR_LOW     8'h48
`define OFF_DIVISOR_HIGH    8'h4C
`define OFF_DIVISOR_FRAC    8'h50
`define OFF_CONFIG          8'h54
`define OFF_IRQ_STATUS      8'h58
`define OFF_IRQ_ENABLE      8'h5C
`define OFF_IRQ_CLEAR       8'h60

// reset values
`define RST_ZERO            8'h00
`define RST_PENDING_SOURCE  8'h01
`define RST_LINE_STATE      8'h60
`define RST_SCRATCH         8'hFF
`define RST_ENH_MODE_SEL    8'h80
`define PWR_DIVISOR_LOW     8'h01
`define PWR_DIVISOR_HIGH    8'h00

// field positions
`define ENH_RSVD_HI         7
`define ENH_RSVD_LO         5
`define CFG_BUS68_BIT       0

// interrupt status bits
`define IRQ_MODEM_CHANGE    0
`define IRQ_RESERVED_WRITE  1
`define IRQ_BITS            2

// axi responses
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

/* tb_uart_reset_state.sv */
/*
 * Self-checking bench for the UART reset-state register file.
 * Assumes the host model drives the AXI4-Lite slave port.
 */
`timescale 1ns/100ps
`default_nettype none
`include "reset_state_defs.vh"
module tb_uart_reset_state;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        power_on_resetn = 1'b0;
	logic [3:0]  modem_in_n = 4'h0;
	logic [3:0]  old;
	logic [7:0]  a, v, dl, dh;
	logic [7:0]  mem [0:127];
	logic [31:0] rv;
	logic [1:0]  rr;
	integer      seed = 26;
	integer      error_cnt = 0;
	integer      n_compared = 0;
	wire [7:0]   s_axi_awaddr, s_axi_araddr;
	wire [31:0]  s_axi_wdata, s_axi_rdata;
	wire [3:0]   s_axi_wstrb;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	wire         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	wire         tx_pos, tx_neg, irq_pin_o, irq_pin_oe, irq;
	uart_reset_state u_dut (.*);
	axi_host u_host (.*);
	initial forever #2 aclk = ~aclk;
	function automatic logic [7:0] rst_val(input logic [7:0] ad);
		case (ad)
			`OFF_PENDING_SOURCE: rst_val = `RST_PENDING_SOURCE;
			`OFF_LINE_STATE: rst_val = `RST_LINE_STATE;
			`OFF_SCRATCH: rst_val = `RST_SCRATCH;
			`OFF_ENH_MODE_SEL: rst_val = `RST_ENH_MODE_SEL;
			`OFF_MODEM_STATE: rst_val = {~modem_in_n, 4'h0};
			`OFF_DIVISOR_LOW: rst_val = dl;
			`OFF_DIVISOR_HIGH: rst_val = dh;
			default: rst_val = `RST_ZERO;
		endcase
	endfunction
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t bit %b expected %b", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp);
		u_host.rd(ad, rv, rr);
		chk_val(rv, exp);
		chk_val({30'h0, rr}, {30'h0, `RESP_OKAY});
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		u_host.wr(ad, {24'h00_0000, d}, rr);
		chk_val({30'h0, rr}, {30'h0, `RESP_OKAY});
	endtask
	task automatic rst_check;
		for (a = 8'h00; a <= 8'h60; a = a + 8'h04)
			rd_chk(a, {24'h00_0000, rst_val(a)});
	endtask
	task automatic reset_pulse(input logic por);
		@(posedge aclk);
		aresetn <= 1'b0;
		power_on_resetn <= ~por;
		repeat (16) @(posedge aclk);
		#1;
		chk_bit(tx_pos && !tx_neg, 1'b1);
		chk_bit(irq_pin_oe, 1'b0);
		@(posedge aclk);
		aresetn <= 1'b1;
		power_on_resetn <= 1'b1;
	endtask
	task automatic report_and_stop;
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		report_and_stop;
	end
	initial begin
		dl = `PWR_DIVISOR_LOW;
		dh = `PWR_DIVISOR_HIGH;
		reset_pulse(1'b1);
		rst_check;
		for (a = 8'h38; a <= 8'h4C; a = a + 8'h04) begin
			v = $random(seed);
			mem[a] = v;
			wr(a, v);
		end
		for (a = 8'h38; a <= 8'h4C; a = a + 8'h04)
			rd_chk(a, {24'h00_0000, mem[a]});
		dl = mem[8'h48];
		dh = mem[8'h4C];
		reset_pulse(1'b0);
		rst_check;
		old = modem_in_n;
		v = $random(seed);
		@(posedge aclk);
		modem_in_n <= modem_in_n ^ (v[3:0] | 4'h1);
		repeat (4) @(posedge aclk);
		rd_chk(`OFF_IRQ_STATUS, 32'h0000_0001);
		chk_bit(irq, 1'b0);
		wr(`OFF_IRQ_ENABLE, 8'h03);
		#1;
		chk_bit(irq, 1'b1);
		rd_chk(`OFF_MODEM_STATE, {24'h00_0000, ~modem_in_n, old ^ modem_in_n});
		rd_chk(`OFF_MODEM_STATE, {24'h00_0000, ~modem_in_n, 4'h0});
		wr(`OFF_IRQ_CLEAR, 8'h01);
		#1;
		chk_bit(irq, 1'b0);
		wr(`OFF_CONFIG, 8'h01);
		repeat (2) @(posedge aclk);
		#1;
		chk_bit(irq_pin_oe && irq_pin_o, 1'b1);
		// reserved bits written nonzero on purpose to raise the event
		wr(`OFF_ENH_FEATURE, 8'hE0);
		repeat (2) @(posedge aclk);
		#1;
		chk_bit(irq && irq_pin_oe && !irq_pin_o, 1'b1);
		reset_pulse(1'b0);
		rst_check;
		u_host.rd(8'h64, rv, rr);
		chk_val({30'h0, rr}, {30'h0, `RESP_SLVERR});
		u_host.wr(8'h7C, 32'h0000_00A5, rr);
		chk_val({30'h0, rr}, {30'h0, `RESP_SLVERR});
		report_and_stop;
	end
endmodule
bind uart_reset_state uart_reset_state_sva u_sva (.*);
`default_nettype wire

/* uart_reset_state.v */
/*
 * Register file of a 16550-style UART with RS-485 driver reset behaviour,
 * reached over AXI4-Lite. Assumes a power-on reset pulse separate from the
 * reset pin, and asynchronous modem pins.
 */
// Function
// - four read/write flow characters, two pause and two resume.
// - power-up loads divisor high 0x00 and low 0x01.
// - reset pin leaves divisor low and high unchanged; only power-up loads them.
// - reset clears modem change bits; upper bits show inverted inputs.
// - transmit pair driven to the line high state during and after reset.
// - interrupt pin floats in 16 mode, driven high in 68 mode; the reset pin clears the 68 mode config bit, so the pin floats after a reset pin pulse.
`timescale 1ns/100ps
`default_nettype none
`include "reset_state_defs.vh"

module uart_reset_state (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        power_on_resetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire [3:0]  modem_in_n,
	output reg         tx_pos,
	output reg         tx_neg,
	output wire        irq_pin_o,
	output wire        irq_pin_oe,
	output wire        irq
);
	reg  [7:0] event_enable_q, fifo_ctrl_q, pending_source_q, line_format_q;
	reg  [7:0] modem_ctrl_q, line_state_q, scratch_q, enh_mode_sel_q;
	reg  [7:0] fill_level_q, threshold_q, fifo_count_q, feature_ctrl_q;
	reg  [7:0] enh_feature_q, divisor_frac_q, divisor_low_q, divisor_high_q;
	reg  [7:0] flow_char_q [0:3];
	reg  [7:0] config_q;
	reg  [1:0] irq_status_q, irq_enable_q;
	reg  [7:0] aw_addr_q;
	reg        aw_held_q, w_held_q;
	reg  [7:0] w_data_q;
	reg        w_lane0_q;
	wire [7:0] modem_state;
	wire       modem_change;
	wire       wr_fire, rd_fire, modem_read, reserved_write;
	reg  [7:0] rd_byte;
	reg        rd_ok;
	wire [1:0] irq_set;
	wire [2:0] rd_slot;

	// decodes a byte offset to one of the flow character slots, or 4 if none
	function [2:0] flow_slot;
		input [7:0] addr;
		begin
			if (addr == `OFF_RESUME_1)
				flow_slot = 3'd0;
			else if (addr == `OFF_RESUME_2)
				flow_slot = 3'd1;
			else if (addr == `OFF_PAUSE_1)
				flow_slot = 3'd2;
			else if (addr == `OFF_PAUSE_2)
				flow_slot = 3'd3;
			else
				flow_slot = 3'd4;
		end
	endfunction

	// write channel: address and data captured in either order
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
	assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q    <= 1'b0;
			w_held_q     <= 1'b0;
			aw_addr_q    <= 8'h00;
			w_data_q     <= 8'h00;
			w_lane0_q    <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q  <= 1'b1;
				w_data_q  <= s_axi_wdata[7:0];
				w_lane0_q <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr_q <= `OFF_IRQ_CLEAR) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read decode; read-only registers answer okay and ignore writes
	assign rd_slot = flow_slot(s_axi_araddr);
	always @* begin
		rd_ok   = 1'b1;
		rd_byte = 8'h00;
		if (rd_slot != 3'd4)
			rd_byte = flow_char_q[rd_slot[1:0]];
		else if (s_axi_araddr == `OFF_EVENT_ENABLE)
			rd_byte = event_enable_q;
		else if (s_axi_araddr == `OFF_FIFO_CTRL)
			rd_byte = fifo_ctrl_q;
		else if (s_axi_araddr == `OFF_PENDING_SOURCE)
			rd_byte = pending_source_q;
		else if (s_axi_araddr == `OFF_LINE_FORMAT)
			rd_byte = line_format_q;
		else if (s_axi_araddr == `OFF_MODEM_CTRL)
			rd_byte = modem_ctrl_q;
		else if (s_axi_araddr == `OFF_LINE_STATE)
			rd_byte = line_state_q;
		else if (s_axi_araddr == `OFF_MODEM_STATE)
			rd_byte = modem_state;
		else if (s_axi_araddr == `OFF_SCRATCH)
			rd_byte = scratch_q;
		else if (s_axi_araddr == `OFF_ENH_MODE_SEL)
			rd_byte = enh_mode_sel_q;
		else if (s_axi_araddr == `OFF_FILL_LEVEL)
			rd_byte = fill_level_q;
		else if (s_axi_araddr == `OFF_THRESHOLD)
			rd_byte = threshold_q;
		else if (s_axi_araddr == `OFF_FIFO_COUNT)
			rd_byte = fifo_count_q;
		else if (s_axi_araddr == `OFF_FEATURE_CTRL)
			rd_byte = feature_ctrl_q;
		else if (s_axi_araddr == `OFF_ENH_FEATURE)
			rd_byte = enh_feature_q;
		else if (s_axi_araddr == `OFF_DIVISOR_LOW)
			rd_byte = divisor_low_q;
		else if (s_axi_araddr == `OFF_DIVISOR_HIGH)
			rd_byte = divisor_high_q;
		else if (s_axi_araddr == `OFF_DIVISOR_FRAC)
			rd_byte = divisor_frac_q;
		else if (s_axi_araddr == `OFF_CONFIG)
			rd_byte = config_q;
		else if (s_axi_araddr == `OFF_IRQ_STATUS)
			rd_byte = {6'h00, irq_status_q};
		else if (s_axi_araddr == `OFF_IRQ_ENABLE)
			rd_byte = {6'h00, irq_enable_q};
		else if (s_axi_araddr == `OFF_IRQ_CLEAR)
			rd_byte = 8'h00;
		else
			rd_ok = 1'b0;
	end

	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;
	assign modem_read    = rd_fire && (s_axi_araddr == `OFF_MODEM_STATE);

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h00_0000, rd_byte};
			s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// reset values of the register file
	always @(posedge aclk) begin
		if (!aresetn) begin
			event_enable_q   <= `RST_ZERO;
			fifo_ctrl_q      <= `RST_ZERO;
			pending_source_q <= `RST_PENDING_SOURCE;
			line_format_q    <= `RST_ZERO;
			modem_ctrl_q     <= `RST_ZERO;
			line_state_q     <= `RST_LINE_STATE;
			scratch_q        <= `RST_SCRATCH;
			enh_mode_sel_q   <= `RST_ENH_MODE_SEL;
			fill_level_q     <= `RST_ZERO;
			threshold_q      <= `RST_ZERO;
			fifo_count_q     <= `RST_ZERO;
			feature_ctrl_q   <= `RST_ZERO;
			enh_feature_q    <= `RST_ZERO;
			divisor_frac_q   <= `RST_ZERO;
			config_q         <= `RST_ZERO;
		end else if (wr_fire && w_lane0_q) begin
			if (aw_addr_q == `OFF_EVENT_ENABLE)
				event_enable_q <= w_data_q;
			else if (aw_addr_q == `OFF_FIFO_CTRL)
				fifo_ctrl_q <= w_data_q;
			else if (aw_addr_q == `OFF_LINE_FORMAT)
				line_format_q <= w_data_q;
			else if (aw_addr_q == `OFF_MODEM_CTRL)
				modem_ctrl_q <= w_data_q;
			else if (aw_addr_q == `OFF_SCRATCH)
				scratch_q <= w_data_q;
			else if (aw_addr_q == `OFF_ENH_MODE_SEL)
				enh_mode_sel_q <= w_data_q;
			else if (aw_addr_q == `OFF_THRESHOLD)
				threshold_q <= w_data_q;
			else if (aw_addr_q == `OFF_FEATURE_CTRL)
				feature_ctrl_q <= w_data_q;
			else if (aw_addr_q == `OFF_ENH_FEATURE)
				enh_feature_q <= w_data_q;
			else if (aw_addr_q == `OFF_DIVISOR_FRAC)
				divisor_frac_q <= w_data_q;
			else if (aw_addr_q == `OFF_CONFIG)
				config_q <= w_data_q;
		end
	end

	// flow characters, one slot per register
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : flow_chars
			always @(posedge aclk) begin
				if (!aresetn)
					flow_char_q[g] <= `RST_ZERO;
				else if (wr_fire && w_lane0_q && flow_slot(aw_addr_q) == g)
					flow_char_q[g] <= w_data_q;
			end
		end
	endgenerate

	// reset pin does not reach the divisor
	always @(posedge aclk) begin
		if (!power_on_resetn) begin
			divisor_low_q  <= `PWR_DIVISOR_LOW;
			divisor_high_q <= `PWR_DIVISOR_HIGH;
		end else if (wr_fire && w_lane0_q) begin
			if (aw_addr_q == `OFF_DIVISOR_LOW)
				divisor_low_q <= w_data_q;
			else if (aw_addr_q == `OFF_DIVISOR_HIGH)
				divisor_high_q <= w_data_q;
		end
	end

	assign reserved_write = wr_fire && w_lane0_q && (aw_addr_q == `OFF_ENH_FEATURE)
		&& (|w_data_q[`ENH_RSVD_HI:`ENH_RSVD_LO]);

	assign irq_set = {reserved_write, modem_change};

	// interrupt status: set wins over a same-cycle clear
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_q <= 2'b00;
			irq_enable_q <= 2'b00;
		end else begin
			if (wr_fire && w_lane0_q && aw_addr_q == `OFF_IRQ_ENABLE)
				irq_enable_q <= w_data_q[1:0];
			if (wr_fire && w_lane0_q && aw_addr_q == `OFF_IRQ_CLEAR)
				irq_status_q <= (irq_status_q & ~w_data_q[1:0]) | irq_set;
			else
				irq_status_q <= irq_status_q | irq_set;
		end
	end

	assign irq = |(irq_status_q & irq_enable_q);

	// line high state, full duplex idle
	always @(posedge aclk) begin
		if (!aresetn) begin
			tx_pos <= 1'b1;
			tx_neg <= 1'b0;
		end else begin
			tx_pos <= 1'b1;
			tx_neg <= 1'b0;
		end
	end

	modem_state_track u_modem (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.modem_in_n   (modem_in_n),
		.read_strobe  (modem_read),
		.modem_state  (modem_state),
		.change_event (modem_change)
	);

	// pin mode follows the bus-mode config bit
	irq_pin_drive u_irq_pin (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.bus68_mode (config_q[`CFG_BUS68_BIT]),
		.irq_active (irq),
		.irq_pin_o  (irq_pin_o),
		.irq_pin_oe (irq_pin_oe)
	);
endmodule
`default_nettype wire

/* uart_reset_state_sva.sv */
/*
 * Port checker for the UART reset-state register file.
 * Assumes one aclk domain with aresetn synchronous, active low.
 */
`timescale 1ns/100ps
`default_nettype none
module uart_reset_state_sva (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        tx_pos,
	input wire logic        tx_neg,
	input wire logic        irq_pin_o,
	input wire logic        irq_pin_oe,
	input wire logic        irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_tx_line_high: assert property (tx_pos && !tx_neg)
		else $error("transmit pair left line high state");
	a_reset_quiet: assert property ($rose(aresetn) |->
		!irq && !irq_pin_oe && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs not at reset state after reset");
	a_pin_float_low: assert property (!irq_pin_oe |-> !irq_pin_o)
		else $error("interrupt pin value while floating");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write answer late");
	a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h60
		|=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
endmodule
`default_nettype wire
